// *** hw/tmr8_pkg.sv ***
`default_nettype none
package tmr8_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_OPTION = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_INTCTL = 8'h02;

    // option register fields
    localparam int OPT_CS_BIT = 5;
    localparam int OPT_SE_BIT = 4;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_PS_LSB = 0;
    localparam int OPT_PS_W = 3;

    // interrupt control fields
    localparam int INT_EN_BIT = 5;
    localparam int INT_FLAG_BIT = 2;

    // reset values
    localparam logic [DATA_W-1:0] OPTION_RESET = 8'hFF;
    localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
    localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;

    // write inhibit after a count write, in instruction cycles
    localparam int INHIBIT_W = 2;
    localparam logic [INHIBIT_W-1:0] INHIBIT_CYCLES = 2'h2;
    localparam logic [INHIBIT_W-1:0] INHIBIT_NONE = 2'h0;
    localparam logic [INHIBIT_W-1:0] INHIBIT_STEP = 2'h1;

    // instruction cycle: clk_i periods per instruction cycle
    localparam int CLK_MHZ = 200;
    localparam int INSTR_DIV_DEFAULT = 4;

    // prescaler geometry
    localparam int PRESC_W = 8;
endpackage
`default_nettype wire

// *** hw/edge_sync.sv ***
`default_nettype none
module edge_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous pin
    input wire logic pin_i,
    // one-cycle edge pulses
    output logic rise_o,
    output logic fall_o
);
    logic sync1;
    logic sync2;
    logic last;

    // two-stage synchroniser, only sync2 is looked at
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            last <= 1'b0;
        end else begin
            sync1 <= pin_i;
            sync2 <= sync1;
            last <= sync2;
        end
    end

    // edge detect on the settled copy
    assign rise_o = sync2 && !last;
    assign fall_o = !sync2 && last;

    // each kind of edge lasts one cycle; a narrow pin pulse may give rise then fall
    property p_edge_pulse;
        @(posedge clk_i) disable iff (rst_i)
        (rise_o |=> !rise_o) and (fall_o |=> !fall_o);
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// *** hw/prescaler.sv ***
`default_nettype none
module prescaler #(
    parameter int W = 8,
    parameter int SEL_W = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clr_i,
    input wire logic [SEL_W-1:0] sel_i,
    // ticks
    input wire logic tick_i,
    output logic tick_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] mask;

    // ratio 2^(sel+1): low sel+1 bits all ones on the incoming tick
    always_comb begin
        mask = '0;
        for (int i = 0; i < W; i++) begin
            mask[i] = ((SEL_W+1)'(i) <= {1'b0, sel_i});
        end
    end

    assign tick_o = tick_i && (&(cnt | ~mask));

    // count is internal only, no bus can reach it
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt <= '0;
        end else if (tick_i) begin
            cnt <= cnt + 1'b1;
        end
    end

    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
        clr_i |=> (cnt == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("prescaler not cleared");

    property p_ratio;
        @(posedge clk_i) disable iff (rst_i)
        tick_o |-> ((cnt & mask) == mask);
    endproperty
    a_ratio: assert property (p_ratio) else $error("prescaler ratio wrong");
endmodule
`default_nettype wire

// *** hw/eight_bit_timer_prescaled.sv ***
`default_nettype none
module eight_bit_timer_prescaled
    import tmr8_pkg::*;
#(
    parameter int INSTR_DIV = INSTR_DIV_DEFAULT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // core status
    input wire logic sleep_i,
    // external count pin, input side only
    input wire logic ext_count_pin_i,
    // watchdog side of the shared prescaler
    input wire logic wdt_tick_i,
    output logic wdt_scaled_o,
    // interrupt
    output logic irq_o
);
    localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);

    // software visible state
    logic [DATA_W-1:0] count_register;
    logic [DATA_W-1:0] option_reg;
    logic overflow_flag;
    logic overflow_int_enable;

    // internal state
    logic [DIV_W-1:0] div_cnt;
    logic instr_tick;
    logic [INHIBIT_W-1:0] inhib_cnt;

    // decoded controls
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [OPT_PS_W-1:0] presc_sel;

    // datapath strobes
    logic pin_rise;
    logic pin_fall;
    logic edge_pulse;
    logic src_tick;
    logic presc_in;
    logic presc_out;
    logic inc_event;
    logic inc;
    logic wr_count;
    logic wr_option;
    logic wr_intctl;
    logic flag_clr;
    logic presc_clr;

    // register decode
    assign wr_count = wr_i && (addr_i == OFF_COUNT);
    assign wr_option = wr_i && (addr_i == OFF_OPTION);
    assign wr_intctl = wr_i && (addr_i == OFF_INTCTL);
    assign flag_clr = wr_intctl && wdata_i[INT_FLAG_BIT];

    // option fields
    assign clock_source_select = option_reg[OPT_CS_BIT];
    assign source_edge_select = option_reg[OPT_SE_BIT];
    assign prescaler_assign = option_reg[OPT_PSA_BIT];
    assign presc_sel = option_reg[OPT_PS_LSB +: OPT_PS_W];

    // instruction cycle enable from the core clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign instr_tick = (div_cnt == DIV_LAST);

    // pin synchroniser and edge detector
    edge_sync u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_count_pin_i),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // pick counting edge
    assign edge_pulse = source_edge_select ? pin_fall : pin_rise;

    // pick source; sleep shuts the timer source off entirely
    assign src_tick = sleep_i ? 1'b0 :
        (clock_source_select ? edge_pulse : instr_tick);

    // prescaler serves exactly one user at a time
    assign presc_in = prescaler_assign ? wdt_tick_i : src_tick;
    assign presc_clr = wr_count && !prescaler_assign;

    prescaler #(
        .W(PRESC_W),
        .SEL_W(OPT_PS_W)
    ) u_presc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(presc_clr),
        .sel_i(presc_sel),
        .tick_i(presc_in),
        .tick_o(presc_out)
    );

    // watchdog only sees scaled ticks while it owns the prescaler
    assign wdt_scaled_o = prescaler_assign && presc_out;

    // increment source: bypass or prescaled
    assign inc_event = prescaler_assign ? src_tick : presc_out;

    // a write in the same cycle takes priority over the increment
    assign inc = inc_event && (inhib_cnt == INHIBIT_NONE) && !wr_count;

    // write inhibit, counted in instruction cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inhib_cnt <= INHIBIT_NONE;
        end else if (wr_count) begin
            inhib_cnt <= INHIBIT_CYCLES;
        end else if (instr_tick && inhib_cnt != INHIBIT_NONE) begin
            inhib_cnt <= inhib_cnt - INHIBIT_STEP;
        end
    end

    // count register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_register <= COUNT_RESET;
        end else if (wr_count) begin
            count_register <= wdata_i;
        end else if (inc) begin
            count_register <= count_register + COUNT_ONE;
        end
    end

    // option register, bits 7:6 kept for the core's other uses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option_reg <= OPTION_RESET;
        end else if (wr_option) begin
            option_reg <= wdata_i;
        end
    end

    // overflow flag: set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
        end else if (inc && count_register == COUNT_MAX) begin
            overflow_flag <= 1'b1;
        end else if (flag_clr) begin
            overflow_flag <= 1'b0;
        end
    end

    // interrupt enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_int_enable <= 1'b0;
        end else if (wr_intctl) begin
            overflow_int_enable <= wdata_i[INT_EN_BIT];
        end
    end

    // level request, masked by the enable
    assign irq_o = overflow_flag && overflow_int_enable;

    // read data valid only in the cycle after the strobe
    // prescaler count has no address on purpose
    always_ff @(posedge clk_i) begin
        if (rst_i || !rd_i) begin
            rdata_o <= READ_ZERO;
        end else begin
            case (addr_i)
                OFF_COUNT: rdata_o <= count_register;
                OFF_OPTION: rdata_o <= option_reg;
                OFF_INTCTL: begin
                    rdata_o <= READ_ZERO;
                    rdata_o[INT_EN_BIT] <= overflow_int_enable;
                    rdata_o[INT_FLAG_BIT] <= overflow_flag;
                end
                default: rdata_o <= READ_ZERO;
            endcase
        end
    end

    // checks

    property p_overflow_sets;
        @(posedge clk_i) disable iff (rst_i)
        (inc && count_register == COUNT_MAX) |=> (overflow_flag && count_register == COUNT_RESET);
    endproperty
    a_overflow_sets: assert property (p_overflow_sets) else $error("wrap did not set flag");

    property p_timer_mode;
        @(posedge clk_i) disable iff (rst_i)
        (!clock_source_select && prescaler_assign && instr_tick && !sleep_i && !wr_count
            && inhib_cnt == INHIBIT_NONE)
        |=> (count_register == $past(count_register) + COUNT_ONE);
    endproperty
    a_timer_mode: assert property (p_timer_mode) else $error("timer mode missed a cycle");

    sequence s_count_write;
        wr_count ##1 (inhib_cnt == INHIBIT_CYCLES && count_register == $past(wdata_i));
    endsequence

    property p_write_loads;
        @(posedge clk_i) disable iff (rst_i)
        wr_count |-> s_count_write;
    endproperty
    a_write_loads: assert property (p_write_loads) else $error("count write not taken");

    property p_inhibit_hold;
        @(posedge clk_i) disable iff (rst_i)
        (inhib_cnt != INHIBIT_NONE && !wr_count) |=> $stable(count_register);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved while inhibited");

    property p_counter_mode;
        @(posedge clk_i) disable iff (rst_i)
        (clock_source_select && prescaler_assign && edge_pulse && !sleep_i && !wr_count
            && inhib_cnt == INHIBIT_NONE)
        |=> (count_register == $past(count_register) + COUNT_ONE);
    endproperty
    a_counter_mode: assert property (p_counter_mode) else $error("edge not counted");

    property p_wrong_edge;
        @(posedge clk_i) disable iff (rst_i)
        (clock_source_select && prescaler_assign && !wr_count
            && (source_edge_select ? pin_rise : pin_fall))
        |=> $stable(count_register);
    endproperty
    a_wrong_edge: assert property (p_wrong_edge) else $error("counted the wrong edge");

    property p_exclusive;
        @(posedge clk_i) disable iff (rst_i)
        !prescaler_assign |-> !wdt_scaled_o;
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("watchdog fed while timer owns");

    property p_no_presc_read;
        @(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i != OFF_COUNT && addr_i != OFF_OPTION && addr_i != OFF_INTCTL)
        |=> (rdata_o == READ_ZERO);
    endproperty
    a_no_presc_read: assert property (p_no_presc_read) else $error("unmapped read not zero");

    property p_irq_mask;
        @(posedge clk_i) disable iff (rst_i)
        irq_o |-> (overflow_int_enable && overflow_flag);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("request while masked");

    property p_flag_sticky;
        @(posedge clk_i) disable iff (rst_i)
        (overflow_flag && !flag_clr) |=> overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself");

    property p_sleep_stop;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_i && !wr_count && !prescaler_assign) ##1 (sleep_i && !wr_count)
        |=> $stable(count_register);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("count moved in sleep");

    property p_sleep_bypass;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_i && prescaler_assign && !wr_count) |=> $stable(count_register);
    endproperty
    a_sleep_bypass: assert property (p_sleep_bypass) else $error("count moved in sleep");
endmodule
`default_nettype wire

// *** test/count_pin_model.sv ***
`default_nettype none
// drives the external count pin the way a slow outside source would
module count_pin_model (
    // clock
    input wire logic clk_i,
    // pin level seen by the timer
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // pin rests low; it is never left floating
    initial begin
        pin_o = 1'b0;
    end

    // one level change, held long enough for the two-stage synchroniser
    task automatic set_level(input logic lvl);
        @(posedge clk_i);
        pin_o <= lvl;
        repeat (5) @(posedge clk_i);
    endtask

    // full low-high-low pulses, one rising and one falling edge each
    task automatic pulses(input int n);
        repeat (n) begin
            set_level(1'b1);
            set_level(1'b0);
        end
    endtask
endmodule
`default_nettype wire

// *** test/eight_bit_timer_prescaled_tb.sv ***
`default_nettype none
module eight_bit_timer_prescaled_tb import tmr8_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int CYCLE_LIMIT = 40000;

    logic clk_i;
    logic rst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic sleep_i;
    logic pin;
    logic wdt_tick_i;
    logic wdt_scaled_o;
    logic irq_o;
    int comparisons = 0;
    int n_fail = 0;
    int cycles = 0;
    int wdt_seen = 0;

    eight_bit_timer_prescaled #(.INSTR_DIV(4)) i_eight_bit_timer_prescaled (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
        .ext_count_pin_i(pin), .wdt_tick_i(wdt_tick_i),
        .wdt_scaled_o(wdt_scaled_o), .irq_o(irq_o)
    );

    count_pin_model i_count_pin_model (.clk_i(clk_i), .pin_o(pin));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // hang guard and watchdog tick tally
    always @(posedge clk_i) begin
        cycles++;
        if (wdt_scaled_o === 1'b1) begin
            wdt_seen++;
        end
        if (cycles == CYCLE_LIMIT) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // single-cycle write strobe, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp, what);
    endtask

    task automatic wdt_ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            wdt_tick_i <= 1'b1;
            @(posedge clk_i);
            wdt_tick_i <= 1'b0;
        end
    endtask

    task automatic test_reset();
        rd_chk(OFF_COUNT, COUNT_RESET, "count reset");
        rd_chk(OFF_OPTION, OPTION_RESET, "option reset");
        rd_chk(OFF_INTCTL, 8'h00, "intctl reset");
        wr(8'h10, 8'hAB);
        rd_chk(8'h10, READ_ZERO, "unmapped");
        $display("test reset done");
    endtask

    // timer mode, prescaler on watchdog: write inhibit, rate, sleep
    task automatic test_timer();
        logic [7:0] a;
        logic [7:0] b;
        int s;
        wr(OFF_OPTION, 8'h08);
        wr(OFF_COUNT, 8'h40);
        repeat (7) @(posedge clk_i);
        rd_chk(OFF_COUNT, 8'h40, "inhibit hold");
        repeat (14) @(posedge clk_i);
        rd_chk(OFF_COUNT, 8'h44, "inhibit end");
        rd(OFF_COUNT, a);
        repeat (38) @(posedge clk_i);
        rd(OFF_COUNT, b);
        chk(b - a, 8'h0A, "timer rate");
        @(posedge clk_i);
        sleep_i <= 1'b1;
        rd(OFF_COUNT, a);
        repeat (38) @(posedge clk_i);
        rd(OFF_COUNT, b);
        chk(b, a, "sleep freeze");
        @(posedge clk_i);
        sleep_i <= 1'b0;
        s = wdt_seen;
        wdt_ticks(8);
        chk({7'h00, wdt_seen != s}, 8'h01, "wdt owns prescaler");
        $display("test timer done");
    endtask

    // timer mode with the prescaler on the timer, then sleep while it stays there
    // a 64-cycle window holds exactly eight 1:2 prescaled ticks whatever the phase
    task automatic test_timer_presc();
        logic [7:0] a;
        logic [7:0] b;
        wr(OFF_OPTION, 8'h00);
        wr(OFF_COUNT, 8'h00);
        repeat (12) @(posedge clk_i);
        rd(OFF_COUNT, a);
        repeat (62) @(posedge clk_i);
        rd(OFF_COUNT, b);
        chk(b - a, 8'h08, "prescaled timer rate");
        @(posedge clk_i);
        sleep_i <= 1'b1;
        rd(OFF_COUNT, a);
        repeat (62) @(posedge clk_i);
        rd(OFF_COUNT, b);
        chk(b, a, "sleep freeze prescaled");
        @(posedge clk_i);
        sleep_i <= 1'b0;
        wr(OFF_OPTION, 8'h08);
        $display("test timer prescaled done");
    endtask

    // overflow flag, mask and write-one clear
    task automatic test_overflow();
        wr(OFF_INTCTL, 8'h04);
        wr(OFF_COUNT, 8'hFD);
        repeat (100) @(posedge clk_i);
        rd_chk(OFF_INTCTL, 8'h04, "flag set and kept");
        chk({7'h00, irq_o}, 8'h00, "masked irq");
        wr(OFF_INTCTL, 8'h20);
        #1;
        chk({7'h00, irq_o}, 8'h01, "enabled irq");
        wr(OFF_INTCTL, 8'h24);
        #1;
        chk({7'h00, irq_o}, 8'h00, "cleared irq");
        rd_chk(OFF_INTCTL, 8'h20, "flag cleared");
        wr(OFF_OPTION, 8'h28);
        wr(OFF_INTCTL, 8'h00);
        $display("test overflow done");
    endtask

    // counter mode: rising then falling edge select
    task automatic test_edges();
        for (int e = 0; e < 2; e++) begin
            wr(OFF_OPTION, (e == 1) ? 8'h38 : 8'h28);
            wr(OFF_COUNT, 8'h00);
            repeat (10) @(posedge clk_i);
            i_count_pin_model.set_level(1'b1);
            rd_chk(OFF_COUNT, (e == 1) ? 8'h00 : 8'h01, "after rise");
            i_count_pin_model.set_level(1'b0);
            rd_chk(OFF_COUNT, 8'h01, "after fall");
        end
        $display("test edges done");
    endtask

    // every ratio, one edge short of two increments, stale prescaler first
    task automatic test_prescaler();
        int s;
        for (int n = 0; n < 8; n++) begin
            wr(OFF_OPTION, 8'h20 | 8'(n));
            i_count_pin_model.pulses(1);
            wr(OFF_COUNT, 8'h00);
            repeat (10) @(posedge clk_i);
            i_count_pin_model.pulses((4 << n) - 1);
            rd_chk(OFF_COUNT, 8'h01, "prescaled count");
            s = wdt_seen;
            wdt_ticks(4);
            chk({7'h00, wdt_seen != s}, 8'h00, "wdt cut off");
        end
        $display("test prescaler done");
    endtask

    initial begin
        rst_i = 1'b1;
        addr_i = '0;
        wdata_i = '0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        sleep_i = 1'b0;
        wdt_tick_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_timer();
        test_timer_presc();
        test_overflow();
        test_edges();
        test_prescaler();
        finish_test();
    end
endmodule
`default_nettype wire
